// >>> bridge_window_config_regs.svh
// register offsets, field positions and reset values of the bridge window registers
`ifndef BRIDGE_WINDOW_CONFIG_REGS_SVH
`define BRIDGE_WINDOW_CONFIG_REGS_SVH

`define OFF_IO_WINDOW_LOW      8'h1c
`define OFF_PREF_WINDOW_LOW    8'h24
`define OFF_PREF_BASE_UPPER    8'h28
`define OFF_PREF_LIMIT_UPPER   8'h2c
`define OFF_IO_UPPER           8'h30
`define OFF_CAP_POINTER        8'h34
`define OFF_INTR_BRIDGE        8'h3c
`define OFF_DECISION_STATUS    8'h48

`define RST_ZERO32             32'h0000_0000
`define RST_ZERO16             16'h0000
`define RST_ZERO12             12'h000
`define RST_ZERO8              8'h00
`define RST_ZERO4              4'h0
`define CAP_POINTER_VALUE      8'h40
`define PREF_ADDR64_CODE       4'h1

`define BC_PARITY_RESPONSE     0
`define BC_ERR_FORWARD         1
`define BC_ISA_ENABLE          2
`define BC_VGA_ENABLE          3
`define BC_VGA_DECODE16        4
`define BC_WIDTH               5

`define VGA_MEM_LOW            64'h0000_0000_000a_0000
`define VGA_MEM_HIGH           64'h0000_0000_000b_ffff
`define VGA_IO_MONO_LOW        10'h3b0
`define VGA_IO_MONO_HIGH       10'h3bb
`define VGA_IO_COLOR_LOW       10'h3c0
`define VGA_IO_COLOR_HIGH      10'h3df
`define ISA_ALIAS_MASK         2'h0
`define LOW_BITS20_ONES        20'hf_ffff
`define LOW_BITS20_ZERO        20'h0_0000
`define LOW_BITS12_ONES        12'hfff
`define LOW_BITS12_ZERO        12'h000

`endif

// >>> bridge_window_pkg.sv
// types shared by the bridge window register bank
package bridge_window_pkg;
   typedef enum logic [1:0] {
      bus_idle = 2'b01,
      bus_ack  = 2'b10
   } bus_state_type;
endpackage : bridge_window_pkg

// >>> bridge_window_config_regs.sv
// bridge window configuration registers with forwarding decision
// Functional notes
// - prefetch limit upper 32 bits, read-write, reset zero, used for forwarding
// - io base upper 16 bits in bits 15:0, read-write, reset zero
// - io limit upper 16 bits in bits 31:16, read-write, reset zero
// - capability pointer byte is read-only and returns 40h
// - interrupt pin byte read-only, reset 00h, sideband load may replace it
// - bridge control bit 16 enables poisoned tlp detection on secondary side
// - bridge control bit 17 enables error message forwarding secondary to primary
// - bit 18 sends window io in first 64KB, top 768 bytes per 1KB, upstream
// - bit 19 forwards vga memory and io ranges when set, ignores when clear
// - vga memory range is 000a0000h to 000bffffh inclusive
// - vga io in first 64KB with bits 9:0 in 3b0-3bbh or 3c0-3dfh
// - bit 20 selects 10-bit or 16-bit vga io address decode
// - prefetch base upper 32 bits, read-write, reset zero, pairs with limit
`include "bridge_window_config_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module bridge_window_config_regs (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [7:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output var  logic [31:0] readdata,
   output var  logic        waitrequest,
   input  wire logic        pin_load,
   input  wire logic [7:0]  pin_load_value,
   input  wire logic        txn_valid,
   input  wire logic        txn_is_io,
   input  wire logic [63:0] txn_addr,
   output var  logic        fwd_valid,
   output var  logic        fwd_downstream,
   output var  logic        fwd_isa_upstream,
   output var  logic        fwd_vga_hit,
   output var  logic        poison_detect_enable,
   output var  logic        secondary_error_forward_enable
);

   bridge_window_pkg::bus_state_type bus_state_r;
   logic [31:0] readdata_r;
   logic [31:0] readdata_nxt;
   logic        accept;
   logic        wr_go;

   logic [31:0] pref_base_upper_r;
   logic [31:0] pref_limit_upper_r;
   logic [11:0] pref_base_low_r;
   logic [11:0] pref_limit_low_r;
   logic [15:0] io_base_upper_r;
   logic [15:0] io_limit_upper_r;
   logic [3:0]  io_base_low_r;
   logic [3:0]  io_limit_low_r;
   logic [7:0]  int_line_r;
   logic [7:0]  int_pin_r;
   logic [`BC_WIDTH-1:0] bridge_ctl_r;

   logic        fwd_valid_r;
   logic        fwd_down_r;
   logic        fwd_isa_r;
   logic        fwd_vga_r;
   logic [3:0]  decision_count_r;

   logic [63:0] pref_base;
   logic [63:0] pref_limit;
   logic [63:0] io_base;
   logic [63:0] io_limit;
   logic        win_hit;
   logic        isa_up;
   logic        vga_hit;
   logic        down_nxt;

   // byte-lane merge of a write into an existing word
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  be);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   function automatic logic in_range(input logic [63:0] a,
                                     input logic [63:0] lo,
                                     input logic [63:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction : in_range

   // first 64KB test shared by isa and vga io decode
   function automatic logic low64k(input logic [63:0] a);
      return a[63:16] == 48'h0000_0000_0000;
   endfunction : low64k

   // bus handshake: one wait cycle, then a single ack cycle
   // a second request is taken only after the ack cycle
   assign accept = (read || write) && (bus_state_r == bridge_window_pkg::bus_idle);
   assign wr_go  = write && (bus_state_r == bridge_window_pkg::bus_ack);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bus_state_r <= bridge_window_pkg::bus_idle;
      end else begin
         case (bus_state_r)
            bridge_window_pkg::bus_idle: begin
               if (accept) begin
                  bus_state_r <= bridge_window_pkg::bus_ack;
               end
            end
            bridge_window_pkg::bus_ack: begin
               bus_state_r <= bridge_window_pkg::bus_idle;
            end
            default: begin
               bus_state_r <= bridge_window_pkg::bus_idle;
            end
         endcase
      end
   end

   // idle and reset show wait, so no request is acked early
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= !accept;
      end
   end

   always_comb begin
      readdata_nxt = `RST_ZERO32;
      case (address)
         `OFF_IO_WINDOW_LOW: begin
            readdata_nxt[7:4]   = io_base_low_r;
            readdata_nxt[15:12] = io_limit_low_r;
         end
         `OFF_PREF_WINDOW_LOW: begin
            readdata_nxt[3:0]   = `PREF_ADDR64_CODE;
            readdata_nxt[15:4]  = pref_base_low_r;
            readdata_nxt[19:16] = `PREF_ADDR64_CODE;
            readdata_nxt[31:20] = pref_limit_low_r;
         end
         `OFF_PREF_BASE_UPPER:  readdata_nxt = pref_base_upper_r;
         `OFF_PREF_LIMIT_UPPER: readdata_nxt = pref_limit_upper_r;
         `OFF_IO_UPPER:         readdata_nxt = {io_limit_upper_r, io_base_upper_r};
         `OFF_CAP_POINTER:      readdata_nxt[7:0] = `CAP_POINTER_VALUE;
         `OFF_INTR_BRIDGE: begin
            readdata_nxt[7:0]   = int_line_r;
            readdata_nxt[15:8]  = int_pin_r;
            readdata_nxt[20:16] = bridge_ctl_r;
         end
         `OFF_DECISION_STATUS: begin
            readdata_nxt[0]   = fwd_valid_r;
            readdata_nxt[1]   = fwd_down_r;
            readdata_nxt[2]   = fwd_isa_r;
            readdata_nxt[3]   = fwd_vga_r;
            readdata_nxt[7:4] = decision_count_r;
         end
         default: readdata_nxt = `RST_ZERO32;
      endcase
   end

   // read data loaded together with the ack, stands during it
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         readdata_r <= `RST_ZERO32;
      end else if (accept && read) begin
         readdata_r <= readdata_nxt;
      end
   end
   assign readdata = readdata_r;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pref_base_upper_r  <= `RST_ZERO32;
         pref_limit_upper_r <= `RST_ZERO32;
      end else if (wr_go) begin
         if (address == `OFF_PREF_BASE_UPPER) begin
            pref_base_upper_r <= merge(pref_base_upper_r, writedata, byteenable);
         end
         if (address == `OFF_PREF_LIMIT_UPPER) begin
            pref_limit_upper_r <= merge(pref_limit_upper_r, writedata, byteenable);
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         io_base_upper_r  <= `RST_ZERO16;
         io_limit_upper_r <= `RST_ZERO16;
      end else if (wr_go && address == `OFF_IO_UPPER) begin
         // io upper: lanes 0-1 base, lanes 2-3 limit
         if (byteenable[0]) begin
            io_base_upper_r[7:0] <= writedata[7:0];
         end
         if (byteenable[1]) begin
            io_base_upper_r[15:8] <= writedata[15:8];
         end
         if (byteenable[2]) begin
            io_limit_upper_r[7:0] <= writedata[23:16];
         end
         if (byteenable[3]) begin
            io_limit_upper_r[15:8] <= writedata[31:24];
         end
      end
   end

   // window low fields, only the writable address bits are held
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pref_base_low_r  <= `RST_ZERO12;
         pref_limit_low_r <= `RST_ZERO12;
         io_base_low_r    <= `RST_ZERO4;
         io_limit_low_r   <= `RST_ZERO4;
      end else if (wr_go) begin
         // type code nibbles are constants and never stored
         if (address == `OFF_PREF_WINDOW_LOW) begin
            if (byteenable[0]) begin
               pref_base_low_r[3:0] <= writedata[7:4];
            end
            if (byteenable[1]) begin
               pref_base_low_r[11:4] <= writedata[15:8];
            end
            if (byteenable[2]) begin
               pref_limit_low_r[3:0] <= writedata[23:20];
            end
            if (byteenable[3]) begin
               pref_limit_low_r[11:4] <= writedata[31:24];
            end
         end
         if (address == `OFF_IO_WINDOW_LOW) begin
            io_base_low_r  <= byteenable[0] ? writedata[7:4] : io_base_low_r;
            io_limit_low_r <= byteenable[1] ? writedata[15:12] : io_limit_low_r;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         int_line_r   <= `RST_ZERO8;
         bridge_ctl_r <= {`BC_WIDTH{1'b0}};
      end else if (wr_go && address == `OFF_INTR_BRIDGE) begin
         if (byteenable[0]) begin
            int_line_r <= writedata[7:0];
         end
         if (byteenable[2]) begin
            bridge_ctl_r <= writedata[20:16];
         end
      end
   end

   // pin byte is read-only to software; only the sideband load changes it
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         int_pin_r <= `RST_ZERO8;
      end else if (pin_load) begin
         int_pin_r <= pin_load_value;
      end
   end

   // registered copies: enables follow the control bits one cycle late
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         poison_detect_enable           <= 1'b0;
         secondary_error_forward_enable <= 1'b0;
      end else begin
         poison_detect_enable           <= bridge_ctl_r[`BC_PARITY_RESPONSE];
         secondary_error_forward_enable <= bridge_ctl_r[`BC_ERR_FORWARD];
      end
   end

   // assembled window bounds
   assign pref_base  = {pref_base_upper_r, pref_base_low_r, `LOW_BITS20_ZERO};
   assign pref_limit = {pref_limit_upper_r, pref_limit_low_r, `LOW_BITS20_ONES};
   assign io_base    = {32'h0000_0000, io_base_upper_r, io_base_low_r, `LOW_BITS12_ZERO};
   assign io_limit   = {32'h0000_0000, io_limit_upper_r, io_limit_low_r, `LOW_BITS12_ONES};

   assign win_hit = txn_is_io ? in_range(txn_addr, io_base, io_limit)
                              : in_range(txn_addr, pref_base, pref_limit);

   // alias test: bits 9:8 nonzero marks the top 768 bytes of a 1KB block
   assign isa_up = txn_is_io && bridge_ctl_r[`BC_ISA_ENABLE] && win_hit &&
                   low64k(txn_addr) && (txn_addr[9:8] != `ISA_ALIAS_MASK);

   // 10-bit decode ignores bits 15:10, so aliases across the 64KB also hit
   always_comb begin
      vga_hit = 1'b0;
      if (bridge_ctl_r[`BC_VGA_ENABLE]) begin
         if (txn_is_io) begin
            vga_hit = low64k(txn_addr) &&
                      (!bridge_ctl_r[`BC_VGA_DECODE16] ||
                       txn_addr[15:10] == 6'h00) &&
                      (in_range({54'h0, txn_addr[9:0]}, {54'h0, `VGA_IO_MONO_LOW},
                                {54'h0, `VGA_IO_MONO_HIGH}) ||
                       in_range({54'h0, txn_addr[9:0]}, {54'h0, `VGA_IO_COLOR_LOW},
                                {54'h0, `VGA_IO_COLOR_HIGH}));
         end else begin
            vga_hit = in_range(txn_addr, `VGA_MEM_LOW, `VGA_MEM_HIGH);
         end
      end
   end

   assign down_nxt = vga_hit || (win_hit && !isa_up);

   // decision registered one cycle after the query
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fwd_valid_r <= 1'b0;
         fwd_down_r  <= 1'b0;
         fwd_isa_r   <= 1'b0;
         fwd_vga_r   <= 1'b0;
      end else begin
         fwd_valid_r <= txn_valid;
         if (txn_valid) begin
            fwd_down_r <= down_nxt;
            fwd_isa_r  <= isa_up;
            fwd_vga_r  <= vga_hit;
         end
      end
   end

   // wraps at 16; software sees the whole 4-bit count in bits 7:4
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         decision_count_r <= `RST_ZERO4;
      end else if (txn_valid) begin
         decision_count_r <= decision_count_r + 4'h1;
      end
   end

   assign fwd_valid        = fwd_valid_r;
   assign fwd_downstream   = fwd_down_r;
   assign fwd_isa_upstream = fwd_isa_r;
   assign fwd_vga_hit      = fwd_vga_r;

endmodule : bridge_window_config_regs

`default_nettype wire

// >>> placeholder_never.sv
// empty unit kept intentionally minimal
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> bridge_window_config_regs_chk.sv
// port assertions for the bridge window register bank
`timescale 1ns/1ps
`default_nettype none
module bridge_window_config_regs_chk (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic [7:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] writedata,
   input wire logic [3:0]  byteenable,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   input wire logic        pin_load,
   input wire logic [7:0]  pin_load_value,
   input wire logic        txn_valid,
   input wire logic        txn_is_io,
   input wire logic [63:0] txn_addr,
   input wire logic        fwd_valid,
   input wire logic        fwd_downstream,
   input wire logic        fwd_isa_upstream,
   input wire logic        fwd_vga_hit,
   input wire logic        poison_detect_enable,
   input wire logic        secondary_error_forward_enable
);
   logic        bc_wr;
   logic [63:0] q_addr;
   logic        q_io;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   assign bc_wr = write && !waitrequest && address == 8'h3c && byteenable[2];
   // query copy so the decision can be tied back to its cause
   always_ff @(posedge clk) begin
      q_addr <= txn_addr;
      q_io   <= txn_is_io;
   end
   property p_answer;
      (read || write) && waitrequest |-> ##[1:2] !waitrequest;
   endproperty
   a_answer: assert property (p_answer) else $error("bus request not answered");
   property p_cap;
      read && !waitrequest && address == 8'h34 |-> readdata[7:0] == 8'h40;
   endproperty
   a_cap: assert property (p_cap) else $error("capability pointer wrong");
   property p_poison;
      bc_wr |-> ##2 poison_detect_enable == $past(writedata[16], 2);
   endproperty
   a_poison: assert property (p_poison) else $error("poison enable not copied");
   property p_err;
      bc_wr |-> ##2 secondary_error_forward_enable == $past(writedata[17], 2);
   endproperty
   a_err: assert property (p_err) else $error("error forward enable not copied");
   property p_fwd;
      fwd_valid == $past(txn_valid);
   endproperty
   a_fwd: assert property (p_fwd) else $error("decision pulse misplaced");
   property p_vga_mem;
      fwd_valid && fwd_vga_hit && !q_io |-> q_addr >= 64'ha_0000 && q_addr <= 64'hb_ffff;
   endproperty
   a_vga_mem: assert property (p_vga_mem) else $error("vga memory hit out of range");
   property p_vga_io;
      fwd_valid && fwd_vga_hit && q_io |-> q_addr[63:16] == 48'h0 &&
         ((q_addr[9:0] >= 10'h3b0 && q_addr[9:0] <= 10'h3bb) ||
          (q_addr[9:0] >= 10'h3c0 && q_addr[9:0] <= 10'h3df));
   endproperty
   a_vga_io: assert property (p_vga_io) else $error("vga io hit out of range");
   property p_vga_down;
      fwd_valid && fwd_vga_hit |-> fwd_downstream;
   endproperty
   a_vga_down: assert property (p_vga_down) else $error("vga hit not forwarded");
   property p_isa;
      fwd_valid && fwd_isa_upstream |-> q_io && q_addr[63:16] == 48'h0 &&
         q_addr[9:8] != 2'h0 && fwd_downstream == fwd_vga_hit;
   endproperty
   a_isa: assert property (p_isa) else $error("isa alias decision wrong");
   c_bc_wr: cover property (bc_wr);
   c_vga: cover property (fwd_valid && fwd_vga_hit);
   c_isa: cover property (fwd_valid && fwd_isa_upstream);
endmodule : bridge_window_config_regs_chk
`default_nettype wire

// >>> host_cfg_master.sv
// host configuration master model on the avalon register bus
`timescale 1ns/1ps
`default_nettype none
module host_cfg_master (
   input  wire logic        clk,
   input  wire logic [31:0] readdata,
   input  wire logic        waitrequest,
   output var  logic [7:0]  address,
   output var  logic        read,
   output var  logic        write,
   output var  logic [31:0] writedata,
   output var  logic [3:0]  byteenable
);
   initial begin
      address = 8'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
      byteenable = 4'h0;
   end
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
      int n;
      @(posedge clk);
      address <= a;
      writedata <= d;
      byteenable <= be;
      read <= !wr;
      write <= wr;
      for (n = 0; n < 16; n++) begin
         @(posedge clk);
         if (!waitrequest) break;
      end
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      // released lines show garbage, not the old value
      address <= ~a;
      writedata <= ~d;
      if (n == 16) begin
         tb_bridge_window_config_regs.failures++;
         tb_bridge_window_config_regs.final_report();
      end
   endtask : xfer
endmodule : host_cfg_master
`default_nettype wire

// >>> tb_bridge_window_config_regs.sv
// testbench for the bridge window register bank
`timescale 1ns/1ps
`default_nettype none
module tb_bridge_window_config_regs;
   logic        clk, resetn, read, write, waitrequest, pin_load, txn_valid, txn_is_io;
   logic        fwd_valid, fwd_downstream, fwd_isa_upstream, fwd_vga_hit;
   logic        poison_detect_enable, secondary_error_forward_enable, io;
   logic [7:0]  address, pin_load_value;
   logic [3:0]  byteenable, iob4, iol4;
   logic [31:0] writedata, readdata, pbu, plu, seed, r;
   logic [63:0] txn_addr;
   logic [15:0] iob, iol;
   logic [11:0] pb12, pl12;
   logic [4:0]  bc;
   int          failures, total_checks;
   logic [63:0] mc [8] = '{64'h1_00ff_ffff, 64'h1_0100_0000, 64'h1_020f_ffff,
      64'h1_0210_0000, 64'h9_ffff, 64'ha_0000, 64'hb_ffff, 64'hc_0000};
   logic [16:0] ic [7] = '{17'h3bb, 17'h3bc, 17'h3c0, 17'h3df, 17'h3e0, 17'h7b0, 17'h1_03b0};
   bridge_window_config_regs bridge_window_config_regs_inst (
      .clk(clk), .resetn(resetn), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .pin_load(pin_load), .pin_load_value(pin_load_value),
      .txn_valid(txn_valid), .txn_is_io(txn_is_io), .txn_addr(txn_addr),
      .fwd_valid(fwd_valid), .fwd_downstream(fwd_downstream),
      .fwd_isa_upstream(fwd_isa_upstream), .fwd_vga_hit(fwd_vga_hit),
      .poison_detect_enable(poison_detect_enable),
      .secondary_error_forward_enable(secondary_error_forward_enable));
   host_cfg_master host_cfg_master_inst (
      .clk(clk), .readdata(readdata), .waitrequest(waitrequest), .address(address),
      .read(read), .write(write), .writedata(writedata), .byteenable(byteenable));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // expected {downstream, isa upstream, vga hit}
   function automatic logic [2:0] exp_fwd(input logic i, input logic [63:0] a);
      logic [63:0] lo, hi;
      logic        win, isa, vga, vio;
      lo = i ? {32'h0, iob, iob4, 12'h000} : {pbu, pb12, 20'h0_0000};
      hi = i ? {32'h0, iol, iol4, 12'hfff} : {plu, pl12, 20'hf_ffff};
      win = a >= lo && a <= hi;
      isa = i && bc[2] && win && a[63:16] == 48'h0 && a[9:8] != 2'h0;
      vio = a[63:16] == 48'h0 && (!bc[4] || a[15:10] == 6'h0) &&
         ((a[9:0] >= 10'h3b0 && a[9:0] <= 10'h3bb) || (a[9:0] >= 10'h3c0 && a[9:0] <= 10'h3df));
      vga = bc[3] && (i ? vio : (a >= 64'ha_0000 && a <= 64'hb_ffff));
      return {vga | (win & !isa), isa, vga};
   endfunction : exp_fwd
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] q;
      host_cfg_master_inst.xfer(1'b1, a, d, be, q);
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string what);
      logic [31:0] q;
      host_cfg_master_inst.xfer(1'b0, a, 32'h0, 4'hf, q);
      chk(what, q, e);
   endtask : rc
   task automatic load_regs();
      wr(8'h28, pbu, 4'hf);
      wr(8'h2c, plu, 4'hf);
      wr(8'h24, {pl12, 4'h0, pb12, 4'h0}, 4'hf);
      wr(8'h30, {iol, iob}, 4'hf);
      wr(8'h1c, {16'h0, iol4, 4'h0, iob4, 4'h0}, 4'h3);
      wr(8'h3c, {11'h0, bc, 16'h0}, 4'h4);
      // enables are copied one cycle after the control write lands
      repeat (2) @(negedge clk);
      chk("poison_en", 32'(poison_detect_enable), 32'(bc[0]));
      chk("err_fwd_en", 32'(secondary_error_forward_enable), 32'(bc[1]));
   endtask : load_regs
   task automatic query(input logic i, input logic [63:0] a);
      logic [2:0] e;
      e = exp_fwd(i, a);
      @(posedge clk);
      txn_valid <= 1'b1;
      txn_is_io <= i;
      txn_addr <= a;
      @(posedge clk);
      txn_valid <= 1'b0;
      @(negedge clk);
      chk("fwd_valid", 32'(fwd_valid), 32'h1);
      chk("fwd_down", 32'(fwd_downstream), 32'(e[2]));
      chk("fwd_isa", 32'(fwd_isa_upstream), 32'(e[1]));
      chk("fwd_vga", 32'(fwd_vga_hit), 32'(e[0]));
   endtask : query
   task automatic final_report();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : final_report
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      {resetn, pin_load, pin_load_value, txn_valid, txn_is_io, txn_addr} = '0;
      {pbu, plu, pb12, pl12, iob, iol, iob4, iol4, bc} = '0;
      failures = 0;
      total_checks = 0;
      seed = 32'd73920;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      rc(8'h2c, 32'h0, "pref_limit_up");
      rc(8'h28, 32'h0, "pref_base_up");
      rc(8'h30, 32'h0, "io_upper");
      rc(8'h34, 32'h40, "cap_ptr");
      rc(8'h3c, 32'h0, "intr_bridge");
      rc(8'h50, 32'h0, "unmapped");
      $display("reset values done");
      // read-only bytes must survive an all-ones write
      wr(8'h34, 32'hffff_ffff, 4'hf);
      rc(8'h34, 32'h40, "cap_ptr_ro");
      wr(8'h3c, 32'hffff_ffff, 4'hf);
      rc(8'h3c, 32'h001f_00ff, "intr_bridge_ones");
      wr(8'h3c, 32'h0, 4'hf);
      @(posedge clk);
      pin_load <= 1'b1;
      pin_load_value <= 8'h01;
      @(posedge clk);
      pin_load <= 1'b0;
      rc(8'h3c, 32'h0000_0100, "pin_load");
      wr(8'h30, 32'hbeef_1234, 4'h3);
      rc(8'h30, 32'h0000_1234, "io_base_lanes");
      wr(8'h30, 32'h5678_0000, 4'hc);
      rc(8'h30, 32'h5678_1234, "io_limit_lanes");
      $display("access kinds done");
      {pbu, plu, pb12, pl12, iol4} = {32'h1, 32'h1, 12'h010, 12'h020, 4'hf};
      for (int d = 0; d < 2; d++) begin
         bc = {d[0], 4'hf};
         iob = 16'h0;
         iol = 16'h0;
         load_regs();
         foreach (mc[k]) query(1'b0, mc[k]);
         foreach (ic[k]) query(1'b1, {47'h0, ic[k]});
      end
      // 30 queries so far: count wraps to 14, last query missed everything
      rc(8'h48, 32'h0000_00e0, "decision_status");
      $display("corner decode done");
      repeat (40) begin
         pbu = rnd() & 32'h3;
         plu = pbu + (rnd() & 32'h1);
         pb12 = 12'(rnd());
         pl12 = 12'(rnd());
         iob = 16'(rnd() & 32'h1);
         iol = iob + 16'(rnd() & 32'h1);
         iob4 = 4'(rnd());
         iol4 = 4'(rnd());
         bc = 5'(rnd());
         load_regs();
         rc(8'h2c, plu, "pref_limit_up_rw");
         rc(8'h28, pbu, "pref_base_up_rw");
         rc(8'h30, {iol, iob}, "io_upper_rw");
         repeat (4) begin
            r = rnd();
            io = r[0];
            query(io, io ? {47'h0, r[17:1]} : {30'h0, r[3:2], rnd()});
         end
      end
      $display("random decode done");
      final_report();
   end
endmodule : tb_bridge_window_config_regs
bind bridge_window_config_regs bridge_window_config_regs_chk chk_inst (.*);
`default_nettype wire
